// ---- ohcim_irq_mask_lists.v ----
`timescale 1ns/100ps
`include "ohcim_defs.vh"

module ohcim_irq_mask_lists #(
  parameter AW = 8
) (
  // clock and reset
  input wire sysClk,
  input wire rst,
  input wire clkEn,
  input wire softReset,
  // register access port
  input wire regWrite,
  input wire regRead,
  input wire [AW-1:0] regAddr,
  input wire [31:0] regWdata,
  output reg [31:0] regRdata,
  // event status from status logic
  input wire [31:0] eventStatus,
  output reg irqRequest,
  // list engine side
  input wire initLoad,
  input wire [31:0] commControlHead,
  input wire [31:0] commBulkHead,
  input wire periodicDone,
  input wire [31:0] periodicNext,
  input wire controlDone,
  input wire [31:0] controlNext,
  input wire controlEnd,
  input wire controlListEnable,
  input wire controlListFilledFlag,
  output reg controlFilledClear,
  // pointer outputs to the list engine
  output reg [31:0] commBaseOut,
  output reg [31:0] periodicCurrentOut,
  output reg [31:0] controlHeadOut,
  output reg [31:0] controlCurrentOut,
  output reg [31:0] bulkHeadOut
);

  // ****************************************
  // register state
  // ****************************************
  reg [31:0] enable_reg;
  reg [31:0] enable_next;
  reg [31:0] commBase_reg;
  reg [31:0] perCur_reg;
  reg [31:0] ctlHead_reg;
  reg [31:0] ctlCur_reg;
  reg [31:0] ctlCur_next;
  reg [31:0] bulkHead_reg;
  reg [31:0] rdata_next;

  wire wrSet = regWrite && (regAddr == `OHCIM_OFF_MASK_SET);
  wire wrClr = regWrite && (regAddr == `OHCIM_OFF_MASK_CLR);
  wire wrBase = regWrite && (regAddr == `OHCIM_OFF_COMM_BASE);
  wire wrCtlCur = regWrite && (regAddr == `OHCIM_OFF_CTL_CUR);
  wire wrBulk = regWrite && (regAddr == `OHCIM_OFF_BULK_HEAD);

  // ****************************************
  // enable set/clear views
  // ****************************************
  always @* begin
    enable_next = enable_reg;
    if (wrSet) begin
      enable_next = enable_next | (regWdata & `OHCIM_ENABLE_BITS);
    end
    if (wrClr) begin
      enable_next = enable_next & ~(regWdata & `OHCIM_ENABLE_BITS);
    end
    enable_next = enable_next & `OHCIM_ENABLE_BITS;
  end

  // ****************************************
  // control current pointer
  // ****************************************
  always @* begin
    ctlCur_next = ctlCur_reg;
    // driver write honoured only while list disabled
    if (wrCtlCur && !controlListEnable) begin
      ctlCur_next = regWdata & `OHCIM_ED_PTR_BITS;
    end
    if (controlDone) begin
      ctlCur_next = controlNext & `OHCIM_ED_PTR_BITS;
    end
    if (controlEnd && controlListFilledFlag) begin
      ctlCur_next = ctlHead_reg;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    rdata_next = 32'h00000000;
    if (regAddr == `OHCIM_OFF_MASK_SET || regAddr == `OHCIM_OFF_MASK_CLR) begin
      rdata_next = enable_reg;
    end else if (regAddr == `OHCIM_OFF_COMM_BASE) begin
      rdata_next = commBase_reg;
    end else if (regAddr == `OHCIM_OFF_PER_CUR) begin
      rdata_next = perCur_reg;
    end else if (regAddr == `OHCIM_OFF_CTL_HEAD) begin
      rdata_next = ctlHead_reg;
    end else if (regAddr == `OHCIM_OFF_CTL_CUR) begin
      rdata_next = ctlCur_reg;
    end else if (regAddr == `OHCIM_OFF_BULK_HEAD) begin
      rdata_next = bulkHead_reg;
    end
  end

  // ****************************************
  // interrupt enable register
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      enable_reg <= `OHCIM_ENABLE_RESET;
    end else if (clkEn) begin
      if (softReset) begin
        enable_reg <= `OHCIM_ENABLE_RESET;
      end else begin
        enable_reg <= enable_next;
      end
    end
  end

  // ****************************************
  // communication area base
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      commBase_reg <= `OHCIM_PTR_RESET;
    end else if (clkEn) begin
      if (softReset) begin
        commBase_reg <= `OHCIM_PTR_RESET;
      end else if (wrBase) begin
        commBase_reg <= regWdata & `OHCIM_COMM_BASE_BITS;
      end
    end
  end

  // ****************************************
  // periodic current pointer
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      perCur_reg <= `OHCIM_PTR_RESET;
    end else if (clkEn) begin
      if (softReset) begin
        perCur_reg <= `OHCIM_PTR_RESET;
      end else if (periodicDone) begin
        perCur_reg <= periodicNext & `OHCIM_ED_PTR_BITS;
      end
    end
  end

  // ****************************************
  // control list head pointer
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      ctlHead_reg <= `OHCIM_PTR_RESET;
    end else if (clkEn) begin
      if (softReset) begin
        ctlHead_reg <= `OHCIM_PTR_RESET;
      end else if (initLoad) begin
        ctlHead_reg <= commControlHead & `OHCIM_ED_PTR_BITS;
      end
    end
  end

  // ****************************************
  // control list current pointer
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      ctlCur_reg <= `OHCIM_PTR_RESET;
    end else if (clkEn) begin
      if (softReset) begin
        ctlCur_reg <= `OHCIM_PTR_RESET;
      end else begin
        ctlCur_reg <= ctlCur_next;
      end
    end
  end

  // ****************************************
  // bulk list head pointer
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      bulkHead_reg <= `OHCIM_PTR_RESET;
    end else if (clkEn) begin
      if (softReset) begin
        bulkHead_reg <= `OHCIM_PTR_RESET;
      end else if (initLoad) begin
        // init load beats a driver write
        bulkHead_reg <= commBulkHead & `OHCIM_ED_PTR_BITS;
      end else if (wrBulk) begin
        bulkHead_reg <= regWdata & `OHCIM_ED_PTR_BITS;
      end
    end
  end

  // ****************************************
  // interrupt request
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      irqRequest <= 1'b0;
    end else if (clkEn) begin
      if (softReset) begin
        irqRequest <= 1'b0;
      end else begin
        irqRequest <= enable_reg[`OHCIM_MASTER_BIT] &&
          (|(eventStatus & enable_reg & `OHCIM_EVENT_BITS));
      end
    end
  end

  // ****************************************
  // filled flag clear pulse
  // ****************************************
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      controlFilledClear <= 1'b0;
    end else if (clkEn) begin
      if (softReset) begin
        controlFilledClear <= 1'b0;
      end else begin
        controlFilledClear <= controlEnd && controlListFilledFlag;
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // held until the next read so software may sample late
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h00000000;
    end else if (clkEn && regRead) begin
      regRdata <= rdata_next;
    end
  end

  // ****************************************
  // pointer copies to the list engine
  // ****************************************
  // registered so every output leaves a flip-flop; one cycle behind
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      commBaseOut <= `OHCIM_PTR_RESET;
      periodicCurrentOut <= `OHCIM_PTR_RESET;
      controlHeadOut <= `OHCIM_PTR_RESET;
      controlCurrentOut <= `OHCIM_PTR_RESET;
      bulkHeadOut <= `OHCIM_PTR_RESET;
    end else if (clkEn) begin
      commBaseOut <= commBase_reg;
      periodicCurrentOut <= perCur_reg;
      controlHeadOut <= ctlHead_reg;
      controlCurrentOut <= ctlCur_reg;
      bulkHeadOut <= bulkHead_reg;
    end
  end

endmodule

// ---- ohcim_defs.vh ----
`ifndef OHCIM_DEFS_VH
`define OHCIM_DEFS_VH
// register offsets (byte addresses inside the operational window)
`define OHCIM_OFF_MASK_SET 8'h10
`define OHCIM_OFF_MASK_CLR 8'h14
`define OHCIM_OFF_COMM_BASE 8'h18
`define OHCIM_OFF_PER_CUR 8'h1c
`define OHCIM_OFF_CTL_HEAD 8'h20
`define OHCIM_OFF_CTL_CUR 8'h24
`define OHCIM_OFF_BULK_HEAD 8'h28
// interrupt enable layout
`define OHCIM_MASTER_BIT 31
`define OHCIM_EVENT_BITS 32'h4000007f
`define OHCIM_ENABLE_BITS 32'hc000007f
`define OHCIM_ENABLE_RESET 32'h00000000
// pointer layouts
`define OHCIM_COMM_BASE_BITS 32'hffffff00
`define OHCIM_ED_PTR_BITS 32'hfffffff0
`define OHCIM_PTR_RESET 32'h00000000
`endif

// ---- ohcim_chk_assertions.sv ----
`timescale 1ns/100ps
module ohcim_chk #(
  parameter AW = 8
) (
  // clock and controls
  input wire sysClk,
  input wire rst,
  input wire clkEn,
  input wire softReset,
  input wire regRead,
  input wire [AW-1:0] regAddr,
  input wire [31:0] regRdata,
  // events and list engine
  input wire [31:0] eventStatus,
  input wire irqRequest,
  input wire controlEnd,
  input wire controlListFilledFlag,
  input wire controlFilledClear,
  input wire [31:0] controlCurrentOut,
  input wire [31:0] controlHeadOut,
  input wire [31:0] commBaseOut
);
  default clocking @(posedge sysClk);
  endclocking
  default disable iff (rst);
  wire fillEnd = controlEnd && controlListFilledFlag && clkEn && !softReset;
  property p_mie_rst; softReset && clkEn |=> ##1 !irqRequest; endproperty
  a_mie_rst: assert property (p_mie_rst) else $error("irq after soft reset");
  property p_irq; irqRequest |-> $past(|(eventStatus & 32'h4000007f)); endproperty
  a_irq: assert property (p_irq) else $error("irq without event");
  property p_base; commBaseOut[7:0] == 8'h00; endproperty
  a_base: assert property (p_base) else $error("base low bits set");
  property p_head; controlHeadOut[3:0] == 4'h0; endproperty
  a_head: assert property (p_head) else $error("head low bits set");
  property p_cur; controlCurrentOut[3:0] == 4'h0; endproperty
  a_cur: assert property (p_cur) else $error("current low bits set");
  property p_fclr; controlFilledClear == $past(fillEnd); endproperty
  a_fclr: assert property (p_fclr) else $error("filled clear timing");
  property p_reload; fillEnd |=> ##1 controlCurrentOut == controlHeadOut; endproperty
  a_reload: assert property (p_reload) else $error("no reload from head");
  property p_unmap; regRead && clkEn && regAddr == 8'h40 |=> regRdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_reload: cover property (fillEnd);
  c_irq: cover property ($rose(irqRequest));
  c_soft: cover property (softReset);
endmodule
bind ohcim_irq_mask_lists ohcim_chk #(.AW(AW)) chk_i (.sysClk, .rst, .clkEn, .softReset,
  .regRead, .regAddr, .regRdata, .eventStatus, .irqRequest, .controlEnd, .controlListFilledFlag,
  .controlFilledClear, .controlCurrentOut, .controlHeadOut, .commBaseOut);

// ---- ohcim_host.sv ----
`timescale 1ns/100ps
module ohcim_host (
  // register access
  input wire sysClk,
  output reg regWrite,
  output reg regRead,
  output reg [7:0] regAddr,
  output reg [31:0] regWdata,
  input wire [31:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
  end
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(negedge sysClk);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge sysClk);
      regWrite = 1'b0;
      // stale data inverted so a dropped write cannot pass unseen
      regWdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [31:0] q);
    begin
      @(negedge sysClk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge sysClk);
      regRead = 1'b0;
      q = regRdata;
    end
  endtask
endmodule

// ---- ohcim_irq_mask_lists_tb.sv ----
`timescale 1ns/100ps
module ohcim_irq_mask_lists_tb;
  reg sysClk = 1'b0, rst = 1'b1, softReset = 1'b0, initLoad = 1'b0, controlEnd = 1'b0;
  reg controlListEnable = 1'b1, controlListFilledFlag = 1'b0;
  reg periodicDone = 1'b0, controlDone = 1'b0;
  reg [31:0] nextPtr = 32'h0;
  wire [31:0] perOut, bulkOut;
  reg [31:0] eventStatus = 32'h0, head = 32'h0, q;
  wire regWrite, regRead, irqRequest;
  wire [7:0] regAddr;
  wire [31:0] regWdata, regRdata;
  integer fail_count = 0, comparisons = 0, cycles = 0, i;
  always #2.5 sysClk = ~sysClk;
  ohcim_host ohcim_host_i (.sysClk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);
  ohcim_irq_mask_lists ohcim_irq_mask_lists_i (.sysClk, .rst, .clkEn(1'b1), .softReset,
    .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .eventStatus, .irqRequest, .initLoad,
    .commControlHead(head), .commBulkHead(head), .periodicDone, .periodicNext(nextPtr),
    .controlDone, .controlNext(nextPtr), .controlEnd, .controlListEnable,
    .controlListFilledFlag, .controlFilledClear(), .commBaseOut(), .periodicCurrentOut(perOut),
    .controlHeadOut(), .controlCurrentOut(), .bulkHeadOut(bulkOut));
  task chk(input [7:0] a, input [31:0] e, input [31:0] s);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED item %h exp %h got %h", a, e, s);
      end
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      ohcim_host_i.rd(a, q);
      chk(a, e, q);
    end
  endtask
  task t_mask;
    begin
      eventStatus = 32'h4000007f;
      for (i = 0; i < 8; i = i + 1) begin
        ohcim_host_i.wr(8'h10, 32'h80000000 | (32'h1 << (i == 7 ? 30 : i)));
        rc(8'h14, 32'h80000000 | (32'h1 << (i == 7 ? 30 : i)));
        chk(8'hff, 32'h1, {31'h0, irqRequest});
        ohcim_host_i.wr(8'h14, 32'h7fffffff);
        rc(8'h10, 32'h80000000);
        chk(8'hff, 32'h0, {31'h0, irqRequest});
      end
      ohcim_host_i.wr(8'h10, 32'h3fffff81);
      rc(8'h10, 32'h80000001);
      ohcim_host_i.wr(8'h14, 32'h80000000);
      rc(8'h14, 32'h00000001);
      chk(8'hff, 32'h0, {31'h0, irqRequest});
      $display("mask test done");
    end
  endtask
  task t_ptrs;
    begin
      ohcim_host_i.wr(8'h18, 32'hffffffff);
      rc(8'h18, 32'hffffff00);
      head = 32'h1234567f;
      @(negedge sysClk) initLoad = 1'b1;
      @(negedge sysClk) initLoad = 1'b0;
      ohcim_host_i.wr(8'h20, 32'h0);
      rc(8'h20, 32'h12345670);
      ohcim_host_i.wr(8'h28, 32'hffffffff);
      rc(8'h28, 32'hfffffff0);
      ohcim_host_i.wr(8'h1c, 32'hffffffff);
      rc(8'h1c, 32'h0);
      ohcim_host_i.wr(8'h24, 32'hffffffff);
      rc(8'h24, 32'h0);
      controlListEnable = 1'b0;
      ohcim_host_i.wr(8'h24, 32'habcdef0f);
      rc(8'h24, 32'habcdef00);
      controlListFilledFlag = 1'b1;
      @(negedge sysClk) controlEnd = 1'b1;
      @(negedge sysClk) controlEnd = 1'b0;
      controlListFilledFlag = 1'b0;
      rc(8'h24, 32'h12345670);
      rc(8'h40, 32'h0);
      nextPtr = 32'h0badcafe;
      @(negedge sysClk);
      periodicDone = 1'b1;
      controlDone = 1'b1;
      @(negedge sysClk);
      periodicDone = 1'b0;
      controlDone = 1'b0;
      rc(8'h1c, 32'h0badcaf0);
      rc(8'h24, 32'h0badcaf0);
      chk(8'hfe, 32'h0badcaf0, perOut);
      chk(8'hfd, 32'hfffffff0, bulkOut);
      $display("pointer test done");
    end
  endtask
  task t_soft;
    begin
      ohcim_host_i.wr(8'h10, 32'hffffffff);
      @(negedge sysClk) softReset = 1'b1;
      @(negedge sysClk) softReset = 1'b0;
      for (i = 0; i < 7; i = i + 1) rc(8'h10 + 4 * i, 32'h0);
      $display("reset test done");
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // hang guard, far above the roughly 140 cycles the tests need
  always @(posedge sysClk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  initial begin
    repeat (6) @(negedge sysClk);
    rst = 1'b0;
    t_soft;
    t_mask;
    t_ptrs;
    test_done;
  end
endmodule
